// [pssq_device.sv]
// Positioning start sequencer: device end, selecting and running stored moves.
`timescale 1ns/1ps
module pssq_device #(
  parameter int unsigned DWELL_TICK = pssq_pkg::DWELL_TICK_CYC
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  pssq_if.dev                         link,
  input  wire logic                   tableWrEn,
  input  wire logic [5:0]             tableWrAddr,
  input  wire pssq_pkg::pssq_entry_t  tableWrData,
  input  wire logic                   mapWrEn,
  input  wire logic [2:0]             mapWrIdx,
  input  wire logic [5:0]             mapWrNum,
  input  wire logic                   alarmClear,
  output logic [pssq_pkg::CMD_W-1:0]  commandPosition,
  output logic [6:0]                  currentEntry,
  output logic [5:0]                  sequenceOrigin
);

  ////////////////////////////////////////////////////////////////////////////
  // Types and state.

  typedef enum logic [1:0] {
    PSSQ_ST_IDLE  = 2'b00,
    PSSQ_ST_LOAD  = 2'b01,
    PSSQ_ST_RUN   = 2'b10,
    PSSQ_ST_DWELL = 2'b11
  } pssq_dev_phase_t;

  typedef struct packed {
    pssq_dev_phase_t                 st;
    logic [5:0]                      num;
    logic [5:0]                      origin;
    logic [6:0]                      cur;
    logic [2:0]                      chain;
    logic                            prevLinked;
    logic                            dir;
    pssq_pkg::pssq_func_t            func;
    logic [pssq_pkg::CMD_W-1:0]      pos;
    logic [pssq_pkg::CMD_W-1:0]      target;
    logic [pssq_pkg::SPD_W-1:0]      speed;
    logic [pssq_pkg::SPD_W-1:0]      opSpeed;
    logic [pssq_pkg::DWELL_W-1:0]    dwell;
    logic [pssq_pkg::TICK_W-1:0]     tick;
    logic [5:0][5:0]                 map;
    logic                            ready;
    logic                            moving;
    logic                            alarm;
  } pssq_dev_state_t;

  localparam int IX_SEL   = 0;
  localparam int IX_START = 6;
  localparam int IX_DIR   = 7;
  localparam int IX_SEQ   = 13;
  localparam int IX_STOP  = 14;
  localparam int IX_EXC   = 15;

  localparam logic [pssq_pkg::TICK_W-1:0] TICK_LAST = pssq_pkg::TICK_W'(DWELL_TICK - 1);

  pssq_dev_state_t       q;
  pssq_dev_state_t       d;
  pssq_pkg::pssq_entry_t dataTable [pssq_pkg::ENTRIES];
  pssq_pkg::pssq_entry_t ent;
  logic [15:0]           inLevel;
  logic [15:0]           inRise;
  logic [pssq_pkg::CMD_W-1:0] remain;
  logic [pssq_pkg::CMD_W-1:0] remMag;
  logic [pssq_pkg::CMD_W-1:0] step;
  logic [pssq_pkg::CMD_W-1:0] newTarget;
  logic [pssq_pkg::CMD_W-1:0] posExt;
  logic [15:0]           speedSq;
  logic                  newDir;
  logic                  startHit;
  logic [5:0]            startNum;
  logic                  seqHit;
  logic [6:0]            nextSeq;
  logic                  nextUsable;
  logic                  abort;
  logic                  linkedThrough;

  ////////////////////////////////////////////////////////////////////////////
  // Operation data table and input synchronisation.

  always_ff @(posedge clk_sys) begin
    if (tableWrEn) begin
      dataTable[tableWrAddr] <= tableWrData;
    end
  end

  pssq_sync #(
    .W(16)
  ) u_sync (
    .clk_sys (clk_sys),
    .reset   (reset),
    .din     ({link.excitationOffInput, link.stopReq, link.sequentialGoInput,
                link.directStart, link.startReq, link.selectBit}),
    .level   (inLevel),
    .rise    (inRise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer and motion profile.

  always_comb begin
    d        = q;
    ent      = dataTable[q.num];
    remain   = q.target - q.pos;
    remMag   = remain[pssq_pkg::CMD_W-1] ? (32'h0 - remain) : remain;
    speedSq  = q.speed * q.speed;
    step     = (remMag < {24'h0, q.speed}) ? remMag : {24'h0, q.speed};
    posExt   = {{8{ent.position[pssq_pkg::POS_W-1]}}, ent.position};
    newTarget = (ent.mode == pssq_pkg::PSSQ_MODE_FROM_HOME) ? posExt :
                (q.target + posExt);
    newDir   = $signed(newTarget) < $signed(q.pos);
    linkedThrough = (q.func == pssq_pkg::PSSQ_FN_LINKED) && (q.num != pssq_pkg::LAST_ENTRY);

    // A select start wins over direct starts; the lowest direct input wins.
    startHit = inRise[IX_START];
    startNum = inLevel[IX_SEL +: 6];
    for (int i = pssq_pkg::NUM_DIRECT - 1; i >= 0; i--) begin
      if (inRise[IX_DIR + i] && !inRise[IX_START]) begin
        startHit = 1'b1;
        startNum = q.map[i];
      end
    end
    seqHit     = inRise[IX_SEQ] && !startHit;
    nextSeq    = q.cur + 7'h01;
    nextUsable = !nextSeq[6] && dataTable[nextSeq[5:0]].seqEnable;
    abort      = inLevel[IX_STOP] || inLevel[IX_EXC];

    // Clearing comes before the phase logic so that an alarm raised in the same cycle wins.
    if (alarmClear) begin
      d.alarm = 1'b0;
    end

    case (q.st)
      PSSQ_ST_IDLE: begin
        d.ready = !q.alarm;
        if ((startHit || seqHit) && q.ready) begin
          d.ready      = 1'b0;
          d.moving     = 1'b1;
          d.st         = PSSQ_ST_LOAD;
          d.chain      = 3'h0;
          d.prevLinked = 1'b0;
          d.speed      = pssq_pkg::START_SPEED;
          if (startHit) begin
            d.num    = startNum;
            d.origin = startNum;
          end else if (nextUsable) begin
            d.num = nextSeq[5:0];
          end else begin
            d.num = q.origin;
          end
        end
      end
      PSSQ_ST_LOAD: begin
        if (q.chain == pssq_pkg::MAX_CHAIN ||
            (q.prevLinked && newDir != q.dir && newTarget != q.pos)) begin
          d.alarm  = 1'b1;
          d.moving = 1'b0;
          d.st     = PSSQ_ST_IDLE;
        end else begin
          d.target  = newTarget;
          d.dir     = newDir;
          d.func    = ent.func;
          d.opSpeed = ent.speed;
          d.dwell   = ent.dwell;
          d.chain   = q.chain + 3'h1;
          d.cur     = {1'b0, q.num};
          d.st      = PSSQ_ST_RUN;
        end
      end
      PSSQ_ST_RUN: begin
        if (remMag == 32'h0) begin
          if (q.func != pssq_pkg::PSSQ_FN_SINGLE && q.num != pssq_pkg::LAST_ENTRY) begin
            d.num        = q.num + 6'h01;
            d.prevLinked = (q.func == pssq_pkg::PSSQ_FN_LINKED);
            if (q.func == pssq_pkg::PSSQ_FN_LINKED) begin
              d.st = PSSQ_ST_LOAD;
            end else begin
              d.st    = PSSQ_ST_DWELL;
              d.tick  = '0;
              d.speed = pssq_pkg::START_SPEED;
            end
          end else begin
            d.st     = PSSQ_ST_IDLE;
            d.ready  = 1'b1;
            d.moving = 1'b0;
            d.speed  = pssq_pkg::START_SPEED;
          end
        end else begin
          d.pos = q.dir ? (q.pos - step) : (q.pos + step);
          if (!linkedThrough && {16'h0, speedSq >> 1} >= remMag &&
              q.speed > pssq_pkg::START_SPEED) begin
            d.speed = q.speed - 8'h01;
          end else if (q.speed < q.opSpeed) begin
            d.speed = q.speed + 8'h01;
          end else if (q.speed > q.opSpeed && q.speed > pssq_pkg::START_SPEED) begin
            d.speed = q.speed - 8'h01;
          end
        end
      end
      PSSQ_ST_DWELL: begin
        if (q.dwell == '0) begin
          d.st = PSSQ_ST_LOAD;
        end else if (q.tick == TICK_LAST) begin
          d.tick  = '0;
          d.dwell = q.dwell - 16'h0001;
        end else begin
          d.tick = q.tick + 17'h00001;
        end
      end
      default: begin
        d.st = PSSQ_ST_IDLE;
      end
    endcase

    if (mapWrEn && mapWrIdx < 3'h6) begin
      d.map[mapWrIdx] = mapWrNum;
    end
    if (abort || alarmClear) begin
      d.origin = pssq_pkg::ORIGIN_RESET;
      d.cur    = pssq_pkg::CUR_NONE;
    end
    if (abort) begin
      d.st     = PSSQ_ST_IDLE;
      d.moving = 1'b0;
      d.ready  = 1'b0;
      d.speed  = pssq_pkg::START_SPEED;
      d.target = q.pos;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q        <= '0;
      q.st     <= PSSQ_ST_IDLE;
      q.origin <= pssq_pkg::ORIGIN_RESET;
      q.cur    <= pssq_pkg::CUR_NONE;
      q.speed  <= pssq_pkg::START_SPEED;
      q.func   <= pssq_pkg::PSSQ_FN_SINGLE;
      q.map    <= pssq_pkg::MAP_DEFAULT;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from state.

  assign link.ready      = q.ready;
  assign link.moving     = q.moving;
  assign link.alarm      = q.alarm;
  assign commandPosition = q.pos;
  assign currentEntry    = q.cur;
  assign sequenceOrigin  = q.origin;

endmodule

// [pssq_host.sv]
// Positioning start sequencer: host end, issuing start handshakes.
`timescale 1ns/1ps
module pssq_host (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  pssq_if.host                      link,
  input  wire logic                 reqValid,
  input  wire pssq_pkg::pssq_kind_t reqKind,
  input  wire logic [5:0]           reqNum,
  input  wire logic                 stopIn,
  input  wire logic                 excitationOffIn,
  output logic                      reqBusy,
  output logic                      reqDone
);

  typedef enum logic [2:0] {
    PSSQ_H_IDLE   = 3'b000,
    PSSQ_H_WAIT   = 3'b001,
    PSSQ_H_SETTLE = 3'b010,
    PSSQ_H_HOLD   = 3'b011,
    PSSQ_H_FINISH = 3'b100
  } pssq_host_phase_t;

  typedef struct packed {
    pssq_host_phase_t     st;
    pssq_pkg::pssq_kind_t kind;
    logic [5:0]           num;
    logic [5:0]           sel;
    logic                 start;
    logic [5:0]           direct;
    logic                 seqGo;
    logic                 stop;
    logic                 excOff;
    logic                 busy;
    logic                 done;
  } pssq_host_state_t;

  pssq_host_state_t q;
  pssq_host_state_t d;

  always_comb begin
    d        = q;
    d.done   = 1'b0;
    d.stop   = stopIn;
    d.excOff = excitationOffIn;
    case (q.st)
      PSSQ_H_IDLE: begin
        if (reqValid) begin
          d.kind = reqKind;
          d.num  = reqNum;
          d.busy = 1'b1;
          d.st   = PSSQ_H_WAIT;
        end
      end
      PSSQ_H_WAIT: begin
        if (link.ready) begin
          if (q.kind == pssq_pkg::PSSQ_KIND_SELECT) begin
            d.sel = q.num;
            d.st  = PSSQ_H_SETTLE;
          end else if (q.kind == pssq_pkg::PSSQ_KIND_NET_SELECT) begin
            d.sel   = q.num;
            d.start = 1'b1;
            d.st    = PSSQ_H_HOLD;
          end else if (q.kind == pssq_pkg::PSSQ_KIND_DIRECT) begin
            d.direct = 6'h01 << q.num[2:0];
            d.st     = PSSQ_H_HOLD;
          end else begin
            d.seqGo = 1'b1;
            d.st    = PSSQ_H_HOLD;
          end
        end
      end
      PSSQ_H_SETTLE: begin
        d.start = 1'b1;
        d.st    = PSSQ_H_HOLD;
      end
      PSSQ_H_HOLD: begin
        if (!link.ready) begin
          d.start  = 1'b0;
          d.direct = 6'h00;
          d.seqGo  = 1'b0;
          d.st     = PSSQ_H_FINISH;
        end
      end
      PSSQ_H_FINISH: begin
        if (link.ready || link.alarm || q.stop || q.excOff) begin
          d.busy = 1'b0;
          d.done = 1'b1;
          d.st   = PSSQ_H_IDLE;
        end
      end
      default: begin
        d.st = PSSQ_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q    <= '0;
      q.st <= PSSQ_H_IDLE;
    end else begin
      q <= d;
    end
  end

  assign link.selectBit          = q.sel;
  assign link.startReq           = q.start;
  assign link.directStart        = q.direct;
  assign link.sequentialGoInput  = q.seqGo;
  assign link.stopReq            = q.stop;
  assign link.excitationOffInput = q.excOff;
  assign reqBusy                 = q.busy;
  assign reqDone                 = q.done;

endmodule

// [pssq_if.sv]
// Link between the host controller and the positioning device.
`timescale 1ns/1ps
interface pssq_if (
  input wire logic clk_sys
);
  logic [5:0] selectBit;
  logic       startReq;
  logic [5:0] directStart;
  logic       sequentialGoInput;
  logic       stopReq;
  logic       excitationOffInput;
  logic       ready;
  logic       moving;
  logic       alarm;

  modport dev (
    input  clk_sys,
    input  selectBit,
    input  startReq,
    input  directStart,
    input  sequentialGoInput,
    input  stopReq,
    input  excitationOffInput,
    output ready,
    output moving,
    output alarm
  );

  modport host (
    input  clk_sys,
    output selectBit,
    output startReq,
    output directStart,
    output sequentialGoInput,
    output stopReq,
    output excitationOffInput,
    input  ready,
    input  moving,
    input  alarm
  );
endinterface

// [pssq_link_asserts.sv]
// Concurrent checks on the link between the host and the positioning device.
`timescale 1ns/1ps
module pssq_link_asserts (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic [5:0] selectBit,
  input wire logic       startReq,
  input wire logic [5:0] directStart,
  input wire logic       sequentialGoInput,
  input wire logic       stopReq,
  input wire logic       excitationOffInput,
  input wire logic       ready,
  input wire logic       moving,
  input wire logic       alarm
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // Counts quiet cycles since reset, stop, excitation off or alarm, saturating at seven.
  logic [2:0] quietQ;
  logic [5:0] dirPrevQ;
  logic       quietOk;
  logic       dirRise;

  always_ff @(posedge clk_sys) begin
    if (reset || stopReq || excitationOffInput || alarm) begin
      quietQ <= 3'h0;
    end else if (quietQ != 3'h7) begin
      quietQ <= quietQ + 3'h1;
    end
    dirPrevQ <= directStart;
  end
  assign quietOk = (quietQ == 3'h7);
  assign dirRise = |(directStart & ~dirPrevQ);

  //////////////////////////////////////////////////////////////////////////////
  sequence s_accept;
    ##[2:4] (moving && !ready);
  endsequence

  chk_select_start: assert property (quietOk && ready && $rose(startReq) |-> s_accept)
    else $error("select start not accepted");
  chk_direct_start: assert property (quietOk && ready && dirRise |-> s_accept)
    else $error("direct start not accepted");
  chk_seq_start: assert property (quietOk && ready && $rose(sequentialGoInput) |-> s_accept)
    else $error("sequential start not accepted");
  chk_ready_moving_excl: assert property (!(ready && moving))
    else $error("ready and moving both high");
  chk_finish_ready: assert property (quietOk && $fell(moving) && !alarm |-> ready)
    else $error("ready not back when move ends");
  chk_ready_return: assert property (quietOk && $rose(ready) |-> $past(moving))
    else $error("ready rose without a finished move");
  chk_host_waits: assert property (
    ($rose(startReq) || $rose(sequentialGoInput) || dirRise) |-> $past(ready))
    else $error("start raised while ready low");
  chk_start_release: assert property ($fell(startReq) |-> !$past(ready))
    else $error("start released before ready fell");
  chk_direct_release: assert property (
    (directStart == 6'h00) && (dirPrevQ != 6'h00) |-> !$past(ready))
    else $error("direct start released before ready fell");
  chk_select_steady: assert property (startReq && $past(startReq) |-> $stable(selectBit))
    else $error("select changed while start held");
  chk_stop_idle: assert property (
    (stopReq || excitationOffInput) [*5] |-> !ready && !moving)
    else $error("device not idle under stop");
  chk_alarm_halts: assert property ($rose(alarm) |-> !ready && !moving)
    else $error("alarm raised while running");
endmodule

// [pssq_pkg.sv]
// Shared constants and types of the positioning start sequencer.
package pssq_pkg;

  localparam int SEL_W      = 6;
  localparam int NUM_DIRECT = 6;
  localparam int POS_W      = 24;
  localparam int CMD_W      = 32;
  localparam int SPD_W      = 8;
  localparam int DWELL_W    = 16;
  localparam int TICK_W     = 17;
  localparam int ENTRIES    = 64;

  localparam logic [5:0] LAST_ENTRY   = 6'h3f;
  localparam logic [5:0] ORIGIN_RESET = 6'h00;
  localparam logic [6:0] CUR_NONE     = 7'h7f;
  localparam logic [2:0] MAX_CHAIN    = 3'h4;
  localparam logic [7:0] START_SPEED  = 8'h01;

  // Default direct-start assignment: input i runs entry i.
  localparam logic [5:0][5:0] MAP_DEFAULT = {6'h05, 6'h04, 6'h03, 6'h02, 6'h01, 6'h00};

  // Dwell is counted in milliseconds.
  localparam int CLK_PERIOD_NS  = 10;
  localparam int DWELL_UNIT_NS  = 1000000;
  localparam int DWELL_TICK_CYC = DWELL_UNIT_NS / CLK_PERIOD_NS;

  typedef enum logic {
    PSSQ_MODE_INC       = 1'b0,
    PSSQ_MODE_FROM_HOME = 1'b1
  } pssq_mode_t;

  typedef enum logic [1:0] {
    PSSQ_FN_SINGLE  = 2'b00,
    PSSQ_FN_LINKED  = 2'b01,
    PSSQ_FN_LINKED2 = 2'b10
  } pssq_func_t;

  typedef enum logic [1:0] {
    PSSQ_KIND_SELECT     = 2'b00,
    PSSQ_KIND_DIRECT     = 2'b01,
    PSSQ_KIND_SEQ        = 2'b10,
    PSSQ_KIND_NET_SELECT = 2'b11
  } pssq_kind_t;

  typedef struct packed {
    logic [POS_W-1:0]   position;
    logic [SPD_W-1:0]   speed;
    pssq_mode_t         mode;
    pssq_func_t         func;
    logic [DWELL_W-1:0] dwell;
    logic               seqEnable;
  } pssq_entry_t;

endpackage

// [pssq_sync.sv]
// Two-flop synchroniser with a rising-edge detector per bit.
`timescale 1ns/1ps
module pssq_sync #(
  parameter int W = 16
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
    logic [W-1:0] last;
  } pssq_sync_state_t;

  pssq_sync_state_t q;
  pssq_sync_state_t d;

  always_comb begin
    d      = q;
    d.meta = din;
    d.sync = q.meta;
    d.last = q.sync;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign level = q.sync;
  assign rise  = q.sync & ~q.last;

endmodule

// [tb_top.sv]
// Self-checking bench joining the host and device ends of the sequencer.
`timescale 1ns/1ps
module tb_top;
  logic                  clk_sys = 1'b0;
  logic                  reset = 1'b1;
  logic                  tableWrEn = 1'b0;
  logic [5:0]            tableWrAddr = 6'h00;
  pssq_pkg::pssq_entry_t tableWrData = '0;
  logic                  mapWrEn = 1'b0;
  logic [2:0]            mapWrIdx = 3'h0;
  logic [5:0]            mapWrNum = 6'h00;
  logic                  alarmClear = 1'b0;
  logic                  reqValid = 1'b0;
  pssq_pkg::pssq_kind_t  reqKind = pssq_pkg::PSSQ_KIND_SELECT;
  logic [5:0]            reqNum = 6'h00;
  logic                  stopIn = 1'b0;
  logic                  excitationOffIn = 1'b0;
  logic [31:0]           commandPosition;
  logic [6:0]            currentEntry;
  logic [5:0]            sequenceOrigin;
  logic                  reqBusy;
  logic                  reqDone;
  int                    bad_count = 0;
  int                    checks = 0;
  int                    fallCnt;
  int                    expPos = 0;
  int                    tPos [64];
  bit                    tAbs [64];
  int                    seqExp [3] = '{1, 2, 0};

  always #5 clk_sys = ~clk_sys;

  pssq_if i_pssq_if (.clk_sys(clk_sys));
  pssq_device #(.DWELL_TICK(4)) i_pssq_device (.clk_sys(clk_sys), .reset(reset),
    .link(i_pssq_if), .tableWrEn(tableWrEn), .tableWrAddr(tableWrAddr),
    .tableWrData(tableWrData), .mapWrEn(mapWrEn), .mapWrIdx(mapWrIdx), .mapWrNum(mapWrNum),
    .alarmClear(alarmClear), .commandPosition(commandPosition), .currentEntry(currentEntry),
    .sequenceOrigin(sequenceOrigin));
  pssq_host i_pssq_host (.clk_sys(clk_sys), .reset(reset), .link(i_pssq_if),
    .reqValid(reqValid), .reqKind(reqKind), .reqNum(reqNum), .stopIn(stopIn),
    .excitationOffIn(excitationOffIn), .reqBusy(reqBusy), .reqDone(reqDone));
  pssq_link_asserts i_pssq_link_asserts (.clk_sys(clk_sys), .reset(reset),
    .selectBit(i_pssq_if.selectBit), .startReq(i_pssq_if.startReq),
    .directStart(i_pssq_if.directStart), .sequentialGoInput(i_pssq_if.sequentialGoInput),
    .stopReq(i_pssq_if.stopReq), .excitationOffInput(i_pssq_if.excitationOffInput),
    .ready(i_pssq_if.ready), .moving(i_pssq_if.moving), .alarm(i_pssq_if.alarm));

  //////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (bad_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    chk_val({31'h0, got}, {31'h0, exp}, what);
  endtask

  task automatic chk_state(input int cur, input int org);
    chk_val(commandPosition, 32'(expPos), "position");
    chk_val(32'(currentEntry), 32'(cur), "entry");
    chk_val(32'(sequenceOrigin), 32'(org), "origin");
    chk_flag(i_pssq_if.ready, 1'b1, "ready");
  endtask

  task automatic wr(input int a, input int p, input bit ab, input int fn, input int dw,
                    input bit sq);
    @(posedge clk_sys);
    tableWrEn   <= 1'b1;
    tableWrAddr <= 6'(a);
    tableWrData <= '{position: 24'(p), speed: 8'h04, mode: pssq_pkg::pssq_mode_t'(ab),
                     func: pssq_pkg::pssq_func_t'(fn), dwell: 16'(dw), seqEnable: sq};
    tPos[a] = p;
    tAbs[a] = ab;
    @(posedge clk_sys);
    tableWrEn <= 1'b0;
  endtask

  task automatic apply(input int e);
    expPos = tAbs[e] ? tPos[e] : expPos + tPos[e];
  endtask

  // Issues one request through the host end and counts falls of moving until done.
  task automatic run(input pssq_pkg::pssq_kind_t k, input int n);
    int   t;
    logic pm;
    @(posedge clk_sys);
    reqValid <= 1'b1;
    reqKind  <= k;
    reqNum   <= 6'(n);
    @(posedge clk_sys);
    reqValid <= 1'b0;
    @(negedge clk_sys);
    chk_flag(reqBusy, 1'b1, "request busy");
    fallCnt = 0;
    t = 0;
    pm = 1'b0;
    while (reqDone !== 1'b1 && t < 3000) begin
      @(negedge clk_sys);
      if (pm === 1'b1 && i_pssq_if.moving === 1'b0) fallCnt++;
      pm = i_pssq_if.moving;
      t++;
    end
    chk_flag(reqDone, 1'b1, "request done");
    chk_flag(reqBusy, 1'b0, "request idle");
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_state(127, 0);
    for (int i = 0; i < 64; i++) wr(i, 1, 1'b0, 0, 0, 1'b0);
    wr(0, 10, 1'b0, 0, 0, 1'b1);
    wr(1, 20, 1'b0, 0, 0, 1'b1);
    wr(2, -5, 1'b0, 0, 0, 1'b1);
    wr(5, 100, 1'b1, 0, 0, 1'b1);
    wr(10, 40, 1'b1, 1, 0, 1'b0);
    wr(11, 60, 1'b1, 0, 0, 1'b0);
    wr(13, 30, 1'b1, 2, 2, 1'b0);
    wr(14, -20, 1'b1, 0, 0, 1'b0);
    for (int i = 20; i < 24; i++) wr(i, 2, 1'b0, 1, 0, 1'b0);
    run(pssq_pkg::PSSQ_KIND_SELECT, 0);
    apply(0);
    chk_state(0, 0);
    for (int i = 0; i < 3; i++) begin
      run(pssq_pkg::PSSQ_KIND_SEQ, 0);
      apply(seqExp[i]);
      chk_state(seqExp[i], 0);
    end
    run(pssq_pkg::PSSQ_KIND_NET_SELECT, 63);
    apply(63);
    chk_state(63, 63);
    for (int i = 0; i < 6; i++) begin
      run(pssq_pkg::PSSQ_KIND_DIRECT, i);
      apply(i);
      chk_state(i, i);
    end
    run(pssq_pkg::PSSQ_KIND_SEQ, 0);
    apply(5);
    chk_state(5, 5);
    @(posedge clk_sys);
    mapWrEn  <= 1'b1;
    mapWrIdx <= 3'h2;
    mapWrNum <= 6'h0d;
    @(posedge clk_sys);
    mapWrEn <= 1'b0;
    run(pssq_pkg::PSSQ_KIND_DIRECT, 2);
    apply(13);
    apply(14);
    chk_state(14, 13);
    run(pssq_pkg::PSSQ_KIND_SELECT, 10);
    apply(10);
    apply(11);
    chk_state(11, 10);
    chk_val(32'(fallCnt), 32'h1, "moving falls");
    run(pssq_pkg::PSSQ_KIND_SELECT, 20);
    chk_flag(i_pssq_if.alarm, 1'b1, "alarm");
    chk_flag(i_pssq_if.ready, 1'b0, "ready in alarm");
    @(posedge clk_sys);
    alarmClear <= 1'b1;
    @(posedge clk_sys);
    alarmClear <= 1'b0;
    repeat (4) @(negedge clk_sys);
    chk_flag(i_pssq_if.alarm, 1'b0, "alarm cleared");
    chk_val(32'(currentEntry), 32'h7f, "entry after clear");
    for (int k = 0; k < 2; k++) begin
      run(pssq_pkg::PSSQ_KIND_SELECT, 5);
      apply(5);
      chk_state(5, 5);
      @(posedge clk_sys);
      stopIn          <= (k == 0);
      excitationOffIn <= (k == 1);
      repeat (8) @(negedge clk_sys);
      chk_flag(i_pssq_if.ready, 1'b0, "ready under stop");
      @(posedge clk_sys);
      stopIn          <= 1'b0;
      excitationOffIn <= 1'b0;
      repeat (8) @(negedge clk_sys);
      chk_state(127, 0);
    end
    wrap_up();
  end
endmodule
